// >>> lamp_pwm_and_sense_mux.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
module lamp_pwm_and_sense_mux
  import lamp_pwm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [3:0]  lamp_drive_request,
  output logic             lamp_output_7,
  output logic             lamp_output_8,
  output logic             lamp_output_9,
  output logic             lamp_output_10,
  output logic [10:0]      sense_route,
  output logic             current_sense_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [15:0] lamp_pwm_ch7_ch8_reg;
  logic [15:0] lamp_pwm_ch9_ch10_reg;
  logic        internal_pwm_enable_reg;
  logic [3:0]  sense_select_code_reg;
  logic [3:0]  pwm_wave;
  logic        sense_active;
  logic [7:0]  reg_index;
  logic        addr_ok;
  logic        req;
  logic        wr_stb;

  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] new_val,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old_val;
    if (sel[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : merge16

  assign reg_index = wb_adr_i[9:2];
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign addr_ok   = (wb_adr_i[31:10] == 22'h0) && (wb_adr_i[1:0] == 2'b00) &&
                     (reg_index >= IDX_PWM_CH7_CH8) && (reg_index <= IDX_SENSE_CTRL);
  // Write lands on the edge where the master samples ack, with the request still held
  assign wr_stb    = wb_cyc_i && wb_stb_i && wb_ack_o && addr_ok && wb_we_i;

  // One wait state: answer one edge after the request is seen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && addr_ok;
      wb_err_o <= req && !addr_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      if (reg_index == IDX_PWM_CH7_CH8) begin
        wb_dat_o <= {16'h0000, lamp_pwm_ch7_ch8_reg};
      end else if (reg_index == IDX_PWM_CH9_CH10) begin
        wb_dat_o <= {16'h0000, lamp_pwm_ch9_ch10_reg};
      end else if (reg_index == IDX_LAMP_CTRL) begin
        wb_dat_o <= {24'h00_0000, pwm_wave, 3'b000, internal_pwm_enable_reg};
      end else if (reg_index == IDX_SENSE_CTRL) begin
        wb_dat_o <= {24'h00_0000, 3'b000, sense_active, sense_select_code_reg};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lamp_pwm_ch7_ch8_reg <= PWM_REG_RESET;
    end else if (wr_stb && reg_index == IDX_PWM_CH7_CH8) begin
      lamp_pwm_ch7_ch8_reg <= merge16(lamp_pwm_ch7_ch8_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lamp_pwm_ch9_ch10_reg <= PWM_REG_RESET;
    end else if (wr_stb && reg_index == IDX_PWM_CH9_CH10) begin
      lamp_pwm_ch9_ch10_reg <= merge16(lamp_pwm_ch9_ch10_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      internal_pwm_enable_reg <= 1'b0;
    end else if (wr_stb && reg_index == IDX_LAMP_CTRL && wb_sel_i[0]) begin
      internal_pwm_enable_reg <= wb_dat_i[INTERNAL_PWM_ENABLE_EN_POS];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sense_select_code_reg <= SENSE_RESET;
    end else if (wr_stb && reg_index == IDX_SENSE_CTRL && wb_sel_i[0]) begin
      sense_select_code_reg <= wb_dat_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Four generator channels

  logic [6:0] duty_word [4];
  logic [3:0] freq_sel;

  assign duty_word[0] = lamp_pwm_ch7_ch8_reg[DUTY_HI_POS +: 7];
  assign duty_word[1] = lamp_pwm_ch7_ch8_reg[DUTY_LO_POS +: 7];
  assign duty_word[2] = lamp_pwm_ch9_ch10_reg[DUTY_HI_POS +: 7];
  assign duty_word[3] = lamp_pwm_ch9_ch10_reg[DUTY_LO_POS +: 7];
  assign freq_sel     = {lamp_pwm_ch9_ch10_reg[FSEL_LO_POS],
                         lamp_pwm_ch9_ch10_reg[FSEL_HI_POS],
                         lamp_pwm_ch7_ch8_reg[FSEL_LO_POS],
                         lamp_pwm_ch7_ch8_reg[FSEL_HI_POS]};

  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    pwm_channel u_ch (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .duty_word   (duty_word[ch]),
      .freq_select (freq_sel[ch]),
      .pwm_out     (pwm_wave[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output selection

  logic [3:0] lamp_q;

  // Disabled generator hands the stage back to the plain on/off request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lamp_q <= 4'h0;
    end else if (internal_pwm_enable_reg) begin
      lamp_q <= pwm_wave;
    end else begin
      lamp_q <= lamp_drive_request;
    end
  end

  assign lamp_output_7  = lamp_q[0];
  assign lamp_output_8  = lamp_q[1];
  assign lamp_output_9  = lamp_q[2];
  assign lamp_output_10 = lamp_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Sense multiplexer

  sense_mux_decode u_sense (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .sense_select_code (sense_select_code_reg),
    .sense_route       (sense_route),
    .sense_active      (sense_active)
  );

  assign current_sense_pin_oe = sense_active;

endmodule : lamp_pwm_and_sense_mux

// >>> lamp_pwm_pkg.sv
// Notes on behaviour
// - Lamp channels 7..10 stay high for (duty word + 1)/128 of each period.
// - Frequency-select bit per channel: clear gives 170 Hz, set gives 225 Hz.
// - Lamp output follows the generator only while internal PWM enable is set.
// - Sense code 0000 selects output 1, 0011 output 4, 0100..1010 outputs 5..11.
// - Codes 0001, 0010 and 1011..1111 deactivate sensing on the shared pin.
// - Outputs 2 and 3 have no sense route; other high-side stages do.
package lamp_pwm_pkg;

  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned PWM_SLOW_HZ    = 170;
  localparam int unsigned PWM_FAST_HZ    = 225;
  localparam int unsigned PWM_STEPS      = 128;
  // Cycles per step, rounded down so the period never runs long
  localparam int unsigned STEP_SLOW_CYC  = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
  localparam int unsigned STEP_FAST_CYC  = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam int unsigned STEP_CNT_W     = 12;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_PWM_CH7_CH8  = 8'h08;
  localparam logic [7:0]  IDX_PWM_CH9_CH10 = 8'h09;
  localparam logic [7:0]  IDX_LAMP_CTRL    = 8'h0A;
  localparam logic [7:0]  IDX_SENSE_CTRL   = 8'h0B;

  localparam logic [15:0] PWM_REG_RESET    = 16'h0000;
  localparam logic [3:0]  SENSE_RESET      = 4'h0;
  localparam int unsigned FSEL_HI_POS      = 15;
  localparam int unsigned FSEL_LO_POS      = 7;
  localparam int unsigned DUTY_HI_POS      = 8;
  localparam int unsigned DUTY_LO_POS      = 0;
  localparam int unsigned INTERNAL_PWM_ENABLE_EN_POS      = 0;

  localparam logic [3:0]  SENSE_OFF_CODE   = 4'hF;

endpackage : lamp_pwm_pkg

// >>> pwm_channel.sv
`timescale 1ns/100ps
module pwm_channel
  import lamp_pwm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [6:0] duty_word,
  input  wire logic       freq_select,
  output logic            pwm_out
);

  logic [STEP_CNT_W-1:0] div_reg;
  logic [6:0]            step_reg;
  logic [STEP_CNT_W-1:0] div_last;
  logic                  step_en;

  // Period length chosen per channel
  assign div_last = freq_select ? STEP_CNT_W'(STEP_FAST_CYC - 1)
                                : STEP_CNT_W'(STEP_SLOW_CYC - 1);
  assign step_en  = (div_reg >= div_last);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (step_en) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + STEP_CNT_W'(1);
    end
  end

  // Free-running 128-step counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_reg <= '0;
    end else if (step_en) begin
      step_reg <= step_reg + 7'd1;
    end
  end

  // Duty 7Fh gives a constant high, 00h gives one step of 128
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (step_reg <= duty_word);
    end
  end

endmodule : pwm_channel

// >>> sense_mux_decode.sv
`timescale 1ns/100ps
module sense_mux_decode
  import lamp_pwm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  sense_select_code,
  output logic [10:0]      sense_route,
  output logic             sense_active
);

  logic [10:0] route_next;

  // Bit n-1 routes output n; outputs 2 and 3 have no path
  always_comb begin
    route_next = 11'h000;
    if (sense_select_code == 4'h0) begin
      route_next[0] = 1'b1;
    end else if (sense_select_code >= 4'h3 && sense_select_code <= 4'hA) begin
      route_next[sense_select_code] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sense_route  <= 11'h001;
      sense_active <= 1'b1;
    end else begin
      sense_route  <= route_next;
      sense_active <= |route_next;
    end
  end

endmodule : sense_mux_decode

// >>> lamp_pwm_sva.sv
`timescale 1ns/100ps
module lamp_pwm_sva (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [10:0] sense_route,
  input wire logic        current_sense_pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_or_err_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  answer_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no answer");
  no_route23_a: assert property (sense_route[2:1] == 2'h0)
    else $error("route to 2 or 3");
  route_onehot_a: assert property ($onehot0(sense_route)) else $error("two routes");
  oe_route_a: assert property (current_sense_pin_oe == (sense_route != 11'h000))
    else $error("oe and route disagree");
  reset_route_a: assert property (disable iff (1'b0) !rst_n |=> sense_route == 11'h001)
    else $error("route not at output 1 after reset");
endmodule : lamp_pwm_sva

// >>> lamp_stage_model.sv
`timescale 1ns/100ps
module lamp_stage_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] lamp,
  output logic [15:0]     fall_at [4]
);
  logic [15:0] cyc_reg;
  logic [3:0]  lamp_reg;
  // A full PWM period is far too long to simulate, so only the first off edge is kept
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cyc_reg  <= 16'h0000;
      lamp_reg <= 4'h0;
      fall_at  <= '{default: 16'h0000};
    end else begin
      cyc_reg  <= cyc_reg + 16'h0001;
      lamp_reg <= lamp;
      for (int i = 0; i < 4; i++) begin
        if (lamp_reg[i] && !lamp[i] && fall_at[i] == 16'h0000) fall_at[i] <= cyc_reg;
      end
    end
  end
endmodule : lamp_stage_model

// >>> lamp_pwm_and_sense_mux_tb.sv
`timescale 1ns/100ps
module lamp_pwm_and_sense_mux_tb;
  import lamp_pwm_pkg::*;
  logic        mclk, rst_n, cyc, stb, we, ack, err, oe, e;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0]  req, lamp, sel, sel_mask;
  logic [11:0] want;
  logic [10:0] route;
  logic [15:0] fall_at [4];
  int          failures, compares;
  lamp_pwm_and_sense_mux DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .lamp_drive_request(req), .lamp_output_7(lamp[0]),
    .lamp_output_8(lamp[1]), .lamp_output_9(lamp[2]), .lamp_output_10(lamp[3]),
    .sense_route(route), .current_sense_pin_oe(oe));
  lamp_stage_model stage (.mclk(mclk), .rst_n(rst_n), .lamp(lamp), .fall_at(fall_at));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if ((got + 16'd4 >= exp && got <= exp + 16'd4) !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: edge at %0d want %0d", $time, got, exp);
    end
  endtask : near
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= sel_mask;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    if (ack !== 1'b1 && err !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    failures = 0;
    compares = 0;
    sel_mask = 4'hF;
    rst_n    <= 1'b0;
    cyc      <= 1'b0;
    stb      <= 1'b0;
    we       <= 1'b0;
    sel      <= 4'h0;
    adr      <= 32'h0000_0000;
    wdat     <= 32'h0000_0000;
    req      <= 4'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 32'h0000_0020, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b1, 32'h0000_0040, 32'h0000_0001);
    chk(e, 1'b1);
    // Byte enables: only the upper byte of the low half may change
    sel_mask = 4'h2;
    bus(1'b1, 32'h0000_0024, 32'h0000_FFFF);
    sel_mask = 4'hF;
    bus(1'b0, 32'h0000_0024, 32'h0000_0000);
    chk(q, 32'h0000_FF00);
    req <= 4'h5;
    repeat (3) @(posedge mclk);
    chk(lamp, 4'h5);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 32'h0000_002C, c);
      repeat (3) @(posedge mclk);
      want = (c == 0 || (c >= 3 && c <= 10)) ? {1'b1, 11'h001 << c} : 12'h000;
      chk({oe, route}, want);
    end
    bus(1'b0, 32'h0000_002C, 32'h0000_0000);
    chk(q, 32'h0000_000F);
    // Second reset restarts the step counters, so the edges below count from here
    req   <= 4'h0;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b1, 32'h0000_0020, 32'h0000_0080);
    bus(1'b1, 32'h0000_0024, 32'h0000_817F);
    bus(1'b0, 32'h0000_0024, 32'h0000_0000);
    chk(q, 32'h0000_817F);
    bus(1'b1, 32'h0000_0028, 32'h0000_0001);
    repeat (5000) @(posedge mclk);
    near(fall_at[0], STEP_SLOW_CYC);
    near(fall_at[1], STEP_FAST_CYC);
    near(fall_at[2], 2 * STEP_FAST_CYC);
    chk(fall_at[3], 32'h0000_0000);
    chk(lamp[3], 1'b1);
    report_and_stop();
  end
endmodule : lamp_pwm_and_sense_mux_tb
bind lamp_pwm_and_sense_mux lamp_pwm_sva u_sva (.mclk(mclk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .sense_route(sense_route), .current_sense_pin_oe(current_sense_pin_oe));
